// File: shared/mdpc_pkg.sv
/*
  Package of the motor driver protection configuration block: register
  indices, field layouts, reset values, response modes and timing counts.
  Assumes a 250 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package mdpc_pkg;

  localparam int CLK_NS = 4;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_FAULT_CTRL = 6'h04;
  localparam logic [5:0] IDX_OC_CFG = 6'h06;
  localparam logic [5:0] IDX_RECT_CFG = 6'h07;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
  localparam logic [5:0] IDX_FAULT_STATE = 6'h13;

  localparam int FAULT_CLEAR_BIT = 0;
  localparam logic [7:0] OC_CFG_RST = 8'h10;
  localparam logic [7:0] RECT_CFG_RST = 8'h00;
  // reserved bits 7, 5 and 4 are not stored
  localparam logic [7:0] RECT_CFG_MASK = 8'h4f;

  localparam int IRQ_W = 2;
  localparam int IRQ_OC_BIT = 0;
  localparam int IRQ_RECOVER_BIT = 1;

  typedef enum logic [1:0] {
    RESP_LATCH = 2'b00,
    RESP_RETRY = 2'b01,
    RESP_REPORT = 2'b10,
    RESP_NONE = 2'b11
  } mdpc_resp_t;

  typedef struct packed {
    logic driver_standby_request;
    logic overcurrent_cycle_clear_en;
    logic [1:0] overcurrent_deglitch_sel;
    logic overcurrent_retry_sel;
    logic overcurrent_level_sel;
    mdpc_resp_t overcurrent_response_sel;
  } mdpc_oc_cfg_t;

  typedef struct packed {
    logic rsv7;
    logic limit_recirculation_sel;
    logic rsv5;
    logic rsv4;
    logic async_rectify_en;
    logic sync_rectify_en;
    logic [1:0] sense_gain_sel;
  } mdpc_rect_cfg_t;

  // deglitch filter times, least times rounded up
  localparam int GLITCH0_NS = 200;
  localparam int GLITCH1_NS = 600;
  localparam int GLITCH2_NS = 1250;
  localparam int GLITCH3_NS = 1600;
  localparam logic [8:0] GLITCH0_CYC = 9'((GLITCH0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] GLITCH1_CYC = 9'((GLITCH1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] GLITCH2_CYC = 9'((GLITCH2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] GLITCH3_CYC = 9'((GLITCH3_NS + CLK_NS - 1) / CLK_NS);

  localparam int RETRY_SHORT_MS = 5;
  localparam int RETRY_LONG_MS = 500;
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_MS * (1000000 / CLK_NS);
  localparam int RETRY_LONG_CYC = RETRY_LONG_MS * (1000000 / CLK_NS);
  localparam int RETRY_W = 27;

endpackage

// File: core/mdpc_regs.sv
/*
  Protection and rectification configuration registers with overcurrent
  fault handling, behind a classic Wishbone slave.
  Assumes comparator and PWM pins are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps

// How it works
// RULE1 - standby bit one enters low-power standby
// RULE2 - cycle-clear bit clears fault on PWM cycle
// RULE3 - deglitch code selects 0.2/0.6/1.25/1.6 us
// RULE4 - overcurrent register resets with deglitch code one
// RULE5 - retry bit selects 5 ms or 500 ms
// RULE6 - level bit selects 16 A or 24 A
// RULE7 - response 0 latches fault until cleared
// RULE8 - response 1 fault clears after retry time
// RULE9 - response 2 reports only; 3 does nothing
// RULE10 - recirculation zero means brake through transistors
// RULE11 - recirculation one means coast through diodes
// RULE12 - async rectification bit enables async rectification
// RULE13 - sync rectification bit enables sync rectification
// RULE14 - sense gain code selects amplifier gain
// RULE15 - rectify register index 7, resets zero
// RULE16 - demagnetization only with both rectifications on
// RULE17 - fault clear bit clears faults, self-resets
// RULE18 - reserved bits stay zero, no effect
module mdpc_regs #(
  parameter int RETRY_SHORT_CYC = mdpc_pkg::RETRY_SHORT_CYC,
  parameter int RETRY_LONG_CYC = mdpc_pkg::RETRY_LONG_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic OC_LOW_CMP_I,
  input wire logic OC_HIGH_CMP_I,
  input wire logic PWM_I,
  output logic STANDBY_O,
  output logic OC_LEVEL_SEL_O,
  output logic FAULT_O,
  output logic SHUTDOWN_O,
  output logic RECIRC_COAST_O,
  output logic ASYNC_RECT_EN_O,
  output logic SYNC_RECT_EN_O,
  output logic DEMAG_EN_O,
  output logic [1:0] SENSE_GAIN_O,
  output logic IRQ_O
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LATCHED = 2'b01,
    ST_RETRY = 2'b10,
    ST_REPORT = 2'b11
  } mdpc_state_t;

  mdpc_pkg::mdpc_oc_cfg_t oc_cfg_q;
  mdpc_pkg::mdpc_rect_cfg_t rect_cfg_q;
  logic [mdpc_pkg::IRQ_W-1:0] irq_status_q;
  logic [mdpc_pkg::IRQ_W-1:0] irq_enable_q;
  logic [mdpc_pkg::IRQ_W-1:0] irq_event;
  logic [mdpc_pkg::IRQ_W-1:0] irq_clear;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic bus_req;
  logic bus_wr;
  logic [5:0] idx;
  logic fault_clear_cmd;
  logic [2:0] pwm_sync_q;
  logic [1:0] oc_low_sync_q;
  logic [1:0] oc_high_sync_q;
  logic pwm_rise;
  logic oc_raw;
  logic [8:0] glitch_cnt_q;
  logic [8:0] glitch_lim;
  logic oc_hold_q;
  logic oc_detect;
  logic oc_act;
  logic [mdpc_pkg::RETRY_W-1:0] retry_cnt_q;
  logic retry_done;
  logic cyc_clear;
  mdpc_state_t state_q;
  mdpc_state_t state_d;

  // every check below runs on the core clock and sleeps through reset
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  // bus slave: one wait state, ack dropped the cycle after it is given
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];
  assign idx = WB_ADR_I[7:2];

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      mdpc_pkg::IDX_OC_CFG: rdata_d[7:0] = oc_cfg_q;
      mdpc_pkg::IDX_RECT_CFG: rdata_d[7:0] = rect_cfg_q;
      mdpc_pkg::IDX_IRQ_STATUS: rdata_d[mdpc_pkg::IRQ_W-1:0] = irq_status_q;
      mdpc_pkg::IDX_IRQ_ENABLE: rdata_d[mdpc_pkg::IRQ_W-1:0] = irq_enable_q;
      mdpc_pkg::IDX_FAULT_STATE: rdata_d[1:0] = state_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      rdata_q <= rdata_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  // configuration writes; lane 0 carries all bits
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      oc_cfg_q <= mdpc_pkg::OC_CFG_RST; // RULE4
    end else if (bus_wr && idx == mdpc_pkg::IDX_OC_CFG) begin
      oc_cfg_q <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rect_cfg_q <= mdpc_pkg::RECT_CFG_RST; // RULE15
    end else if (bus_wr && idx == mdpc_pkg::IDX_RECT_CFG) begin
      rect_cfg_q <= WB_DAT_I[7:0] & mdpc_pkg::RECT_CFG_MASK; // RULE18
    end
  end

  // clear command acts once; nothing is stored, so it reads back zero
  assign fault_clear_cmd = bus_wr && idx == mdpc_pkg::IDX_FAULT_CTRL
    && WB_DAT_I[mdpc_pkg::FAULT_CLEAR_BIT]; // RULE17

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_enable_q <= '0;
    end else if (bus_wr && idx == mdpc_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_q <= WB_DAT_I[mdpc_pkg::IRQ_W-1:0];
    end
  end

  assign irq_clear = (bus_wr && idx == mdpc_pkg::IDX_IRQ_CLEAR) ?
    WB_DAT_I[mdpc_pkg::IRQ_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  assign IRQ_O = |(irq_status_q & irq_enable_q);

  // pin synchronisers
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwm_sync_q <= 3'h0;
      oc_low_sync_q <= 2'h0;
      oc_high_sync_q <= 2'h0;
    end else begin
      pwm_sync_q <= {pwm_sync_q[1:0], PWM_I};
      oc_low_sync_q <= {oc_low_sync_q[0], OC_LOW_CMP_I};
      oc_high_sync_q <= {oc_high_sync_q[0], OC_HIGH_CMP_I};
    end
  end

  assign pwm_rise = pwm_sync_q[1] & ~pwm_sync_q[2];
  assign oc_raw = oc_cfg_q.overcurrent_level_sel ? oc_high_sync_q[1] : oc_low_sync_q[1]; // RULE6
  assign OC_LEVEL_SEL_O = oc_cfg_q.overcurrent_level_sel; // RULE6

  always_comb begin
    unique case (oc_cfg_q.overcurrent_deglitch_sel) // RULE3
      2'h0: glitch_lim = mdpc_pkg::GLITCH0_CYC;
      2'h1: glitch_lim = mdpc_pkg::GLITCH1_CYC;
      2'h2: glitch_lim = mdpc_pkg::GLITCH2_CYC;
      2'h3: glitch_lim = mdpc_pkg::GLITCH3_CYC;
    endcase
  end

  // one detection per continuous overcurrent episode
  assign oc_detect = oc_raw && !oc_hold_q && (glitch_cnt_q + 9'h001 >= glitch_lim); // RULE3

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      glitch_cnt_q <= 9'h000;
      oc_hold_q <= 1'b0;
    end else if (!oc_raw) begin
      glitch_cnt_q <= 9'h000;
      oc_hold_q <= 1'b0;
    end else if (oc_detect) begin
      oc_hold_q <= 1'b1;
    end else if (!oc_hold_q) begin
      glitch_cnt_q <= glitch_cnt_q + 9'h001;
    end
  end

  // response mode 3 neither reports nor acts
  assign oc_act = oc_detect && oc_cfg_q.overcurrent_response_sel != mdpc_pkg::RESP_NONE; // RULE9

  assign retry_done = state_q == ST_RETRY && retry_cnt_q == '0;
  assign cyc_clear = oc_cfg_q.overcurrent_cycle_clear_en && pwm_rise; // RULE2
  assign irq_event = {retry_done, oc_act};

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      retry_cnt_q <= '0;
    end else if (oc_act) begin
      retry_cnt_q <= oc_cfg_q.overcurrent_retry_sel ? // RULE5
        mdpc_pkg::RETRY_W'(RETRY_LONG_CYC - 1) : mdpc_pkg::RETRY_W'(RETRY_SHORT_CYC - 1);
    end else if (state_q == ST_RETRY && retry_cnt_q != '0) begin
      retry_cnt_q <= retry_cnt_q - 1'b1;
    end
  end

  // a new detection in the clearing cycle keeps or re-arms the fault
  always_comb begin
    state_d = state_q;
    if (oc_act) begin
      unique case (oc_cfg_q.overcurrent_response_sel)
        mdpc_pkg::RESP_LATCH: state_d = ST_LATCHED; // RULE7
        mdpc_pkg::RESP_RETRY: state_d = ST_RETRY; // RULE8
        mdpc_pkg::RESP_REPORT: state_d = ST_REPORT; // RULE9
        mdpc_pkg::RESP_NONE: state_d = state_q;
      endcase
    end else if (fault_clear_cmd || cyc_clear || retry_done) begin // RULE17 RULE2 RULE8
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign FAULT_O = state_q != ST_IDLE;
  // report-only keeps the bridge running
  assign SHUTDOWN_O = state_q == ST_LATCHED || state_q == ST_RETRY; // RULE7 RULE8 RULE9
  assign STANDBY_O = oc_cfg_q.driver_standby_request; // RULE1
  assign RECIRC_COAST_O = rect_cfg_q.limit_recirculation_sel; // RULE10 RULE11
  assign ASYNC_RECT_EN_O = rect_cfg_q.async_rectify_en; // RULE12
  assign SYNC_RECT_EN_O = rect_cfg_q.sync_rectify_en; // RULE13
  assign DEMAG_EN_O = rect_cfg_q.async_rectify_en & rect_cfg_q.sync_rectify_en; // RULE16
  assign SENSE_GAIN_O = rect_cfg_q.sense_gain_sel; // RULE14

  logic wr_oc_q;
  logic wr_rect_q;
  logic [7:0] wdat_q;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_oc_q <= 1'b0;
      wr_rect_q <= 1'b0;
      wdat_q <= 8'h00;
    end else begin
      wr_oc_q <= bus_wr && idx == mdpc_pkg::IDX_OC_CFG;
      wr_rect_q <= bus_wr && idx == mdpc_pkg::IDX_RECT_CFG;
      wdat_q <= WB_DAT_I[7:0];
    end
  end

  a_standby_write: // RULE1
    assert property (wr_oc_q |-> STANDBY_O == wdat_q[7])
    else $error("standby output does not follow write");

  a_level_write: // RULE6
    assert property (wr_oc_q |-> OC_LEVEL_SEL_O == wdat_q[2])
    else $error("level select output does not follow write");

  a_reset_values: // RULE4
    assert property (!$past(RST_B_I) |-> oc_cfg_q == mdpc_pkg::OC_CFG_RST
      && rect_cfg_q == mdpc_pkg::RECT_CFG_RST)
    else $error("configuration reset value wrong");

  a_cycle_clear_off: // RULE2
    assert property (state_q == ST_LATCHED && pwm_rise && !oc_cfg_q.overcurrent_cycle_clear_en
      && !fault_clear_cmd && !oc_act |=> state_q == ST_LATCHED)
    else $error("latched fault cleared by pwm cycle while disabled");

  a_glitch_filter: // RULE3
    assert property (oc_detect |-> oc_raw && glitch_cnt_q == glitch_lim - 9'h001)
    else $error("overcurrent detected before deglitch time");

  a_latch_holds: // RULE7
    assert property (state_q == ST_LATCHED && !fault_clear_cmd && !cyc_clear && !oc_act
      |=> state_q == ST_LATCHED && SHUTDOWN_O)
    else $error("latched fault released without clear");

  a_retry_short: // RULE5
    assert property (oc_act && !oc_cfg_q.overcurrent_retry_sel
      |=> retry_cnt_q == mdpc_pkg::RETRY_W'(RETRY_SHORT_CYC - 1))
    else $error("retry wait not the short setting");

  a_retry_long: // RULE5
    assert property (oc_act && oc_cfg_q.overcurrent_retry_sel
      |=> retry_cnt_q == mdpc_pkg::RETRY_W'(RETRY_LONG_CYC - 1))
    else $error("retry wait not the long setting");

  a_retry_ends: // RULE8
    assert property (retry_done && !oc_act |=> !FAULT_O && !SHUTDOWN_O)
    else $error("retry fault did not clear after retry time");

  a_report_only: // RULE9
    assert property (oc_act && oc_cfg_q.overcurrent_response_sel == mdpc_pkg::RESP_REPORT
      |=> FAULT_O && !SHUTDOWN_O)
    else $error("report-only mode took action");

  a_mode_silent: // RULE9
    assert property (state_q == ST_IDLE && oc_detect
      && oc_cfg_q.overcurrent_response_sel == mdpc_pkg::RESP_NONE |=> !FAULT_O)
    else $error("silent mode reported overcurrent");

  a_rect_reserved: // RULE18
    assert property (wr_rect_q |-> rect_cfg_q == (wdat_q & mdpc_pkg::RECT_CFG_MASK))
    else $error("rectify register reserved bits stored");

  a_rect_fields: // RULE10 RULE11 RULE12 RULE13 RULE14
    assert property (wr_rect_q |-> RECIRC_COAST_O == wdat_q[6] && ASYNC_RECT_EN_O == wdat_q[3]
      && SYNC_RECT_EN_O == wdat_q[2] && SENSE_GAIN_O == wdat_q[1:0])
    else $error("rectify outputs do not follow write");

  a_demag_pair: // RULE16
    assert property (wr_rect_q |-> DEMAG_EN_O == (wdat_q[3] && wdat_q[2]))
    else $error("demagnetization without both rectifications");

  a_clear_fault: // RULE17
    assert property (fault_clear_cmd && !oc_act |=> state_q == ST_IDLE && !FAULT_O)
    else $error("fault clear command ignored");

  c_latch_cleared: cover property (state_q == ST_LATCHED ##1 fault_clear_cmd ##1 state_q == ST_IDLE);
  c_retry_done: cover property (retry_done ##1 state_q == ST_IDLE);
  c_report: cover property (state_q == ST_REPORT);
  c_cycle_clear: cover property (state_q == ST_LATCHED && cyc_clear);
  c_silent: cover property (oc_detect && oc_cfg_q.overcurrent_response_sel == mdpc_pkg::RESP_NONE);

endmodule // mdpc_regs

// File: sim/tb.sv
/*
  Self-checking bench for the protection configuration registers: bus reads and writes,
  overcurrent fault modes, deglitch timing, retry, cycle clear and interrupts.
  Assumes the design answers each Wishbone request with a one-cycle registered ack.
*/
`timescale 1ns/100ps
module tb;
  localparam int RS = 20;
  localparam int RL = 40;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, cmp_lo = 1'b0, cmp_hi = 1'b0, pwm = 1'b0;
  logic stby, lvl, fault, shut, coast, ar, sr, dm, irq;
  logic [1:0] gain;
  int miscompares = 0;
  int n_tests = 0;

  mdpc_regs #(.RETRY_SHORT_CYC(RS), .RETRY_LONG_CYC(RL)) u_mdpc_regs (
    .CLOCK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .OC_LOW_CMP_I(cmp_lo), .OC_HIGH_CMP_I(cmp_hi), .PWM_I(pwm), .STANDBY_O(stby),
    .OC_LEVEL_SEL_O(lvl), .FAULT_O(fault), .SHUTDOWN_O(shut), .RECIRC_COAST_O(coast),
    .ASYNC_RECT_EN_O(ar), .SYNC_RECT_EN_O(sr), .DEMAG_EN_O(dm), .SENSE_GAIN_O(gain), .IRQ_O(irq)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  // one classic cycle; the answer is taken only at the edge where ack is seen
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic wait_fault(input logic v, input int lim, output int n);
    n = 0;
    while (fault !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic fault_up(input logic hi, output int n);
    @(posedge clk);
    if (hi) cmp_hi <= 1'b1;
    else cmp_lo <= 1'b1;
    wait_fault(1'b1, 600, n);
    cmp_hi <= 1'b0;
    cmp_lo <= 1'b0;
  endtask

  task automatic clr();
    logic [31:0] r;
    int n;
    wb(1'b1, mdpc_pkg::IDX_FAULT_CTRL, 8'h01, r);
    wait_fault(1'b0, 8, n);
    repeat (2) @(posedge clk);
  endtask

  function automatic int deg_n(input int c);
    int ns[4] = '{200, 600, 1250, 1600};
    return (ns[c] + 3) / 4;
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] v;
    int n;
    r = $urandom(97);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wb(1'b0, mdpc_pkg::IDX_OC_CFG, 8'h00, r);
    chk(r, 32'h10);
    wb(1'b0, mdpc_pkg::IDX_RECT_CFG, 8'h00, r);
    chk(r, 32'h0);
    chk({21'h0, stby, lvl, fault, shut, coast, ar, sr, dm, gain, irq}, 32'h0);
    wb(1'b0, 6'h3f, 8'h00, r);
    chk(r, 32'h0);
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'hff : {8'($urandom) & 8'hfc} | 8'(i % 4);
      wb(1'b1, mdpc_pkg::IDX_RECT_CFG, v, r);
      wb(1'b0, mdpc_pkg::IDX_RECT_CFG, 8'h00, r);
      chk(r, {24'h0, v & 8'h4f});
      chk(coast, v[6]);
      chk({ar, sr}, v[3:2]);
      chk(dm, v[3] & v[2]);
      chk(gain, v[1:0]);
    end
    // a write without lane 0 must leave the register alone
    sel <= 4'he;
    wb(1'b1, mdpc_pkg::IDX_RECT_CFG, ~v, r);
    sel <= 4'hf;
    wb(1'b0, mdpc_pkg::IDX_RECT_CFG, 8'h00, r);
    chk(r, {24'h0, v & 8'h4f});
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) | 8'h03;
      wb(1'b1, mdpc_pkg::IDX_OC_CFG, v, r);
      wb(1'b0, mdpc_pkg::IDX_OC_CFG, 8'h00, r);
      chk(r, {24'h0, v});
      chk(stby, v[7]);
      chk(lvl, v[2]);
    end
    // a pulse shorter than the filter must be swallowed
    wb(1'b1, mdpc_pkg::IDX_OC_CFG, 8'h00, r);
    cmp_lo <= 1'b1;
    repeat (40) @(posedge clk);
    cmp_lo <= 1'b0;
    repeat (60) @(posedge clk);
    chk(fault, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, mdpc_pkg::IDX_OC_CFG, {2'b00, 2'(i), 4'h0}, r);
      fault_up(1'b0, n);
      chk(n >= deg_n(i) && n <= deg_n(i) + 5, 1'b1);
      repeat (20) @(posedge clk);
      chk({fault, shut}, 2'b11);
      clr();
      wb(1'b0, mdpc_pkg::IDX_FAULT_CTRL, 8'h00, r);
      chk(r, 32'h0);
    end
    // level 24 A: the 16 A comparator alone must not trip
    wb(1'b1, mdpc_pkg::IDX_OC_CFG, 8'h04, r);
    cmp_lo <= 1'b1;
    repeat (100) @(posedge clk);
    cmp_lo <= 1'b0;
    chk(fault, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, mdpc_pkg::IDX_OC_CFG, {4'h0, 1'(i), 3'b101}, r);
      fault_up(1'b1, n);
      chk(shut, 1'b1);
      wait_fault(1'b0, 200, n);
      chk(n >= (i ? RL : RS) - 4 && n <= (i ? RL : RS) + 4, 1'b1);
      wb(1'b0, mdpc_pkg::IDX_IRQ_STATUS, 8'h00, r);
      chk(r, 32'h3);
      wb(1'b1, mdpc_pkg::IDX_IRQ_CLEAR, 8'h03, r);
      wb(1'b0, mdpc_pkg::IDX_IRQ_STATUS, 8'h00, r);
      chk(r, 32'h0);
    end
    wb(1'b1, mdpc_pkg::IDX_IRQ_ENABLE, 8'h01, r);
    wb(1'b1, mdpc_pkg::IDX_OC_CFG, 8'h02, r);
    fault_up(1'b0, n);
    repeat (2) @(posedge clk);
    chk({shut, irq}, 2'b01);
    wb(1'b1, mdpc_pkg::IDX_IRQ_ENABLE, 8'h00, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wb(1'b1, mdpc_pkg::IDX_IRQ_ENABLE, 8'h01, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, mdpc_pkg::IDX_IRQ_CLEAR, 8'h01, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    clr();
    wb(1'b1, mdpc_pkg::IDX_OC_CFG, 8'h03, r);
    cmp_lo <= 1'b1;
    repeat (100) @(posedge clk);
    cmp_lo <= 1'b0;
    wb(1'b0, mdpc_pkg::IDX_IRQ_STATUS, 8'h00, r);
    chk({r[0], irq, fault}, 3'b000);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, mdpc_pkg::IDX_OC_CFG, {1'b0, 1'(i), 6'h00}, r);
      fault_up(1'b0, n);
      repeat (5) @(posedge clk);
      pwm <= 1'b1;
      repeat (10) @(posedge clk);
      pwm <= 1'b0;
      chk(fault, 1'(i == 0));
      clr();
    end
    end_sim();
  end
endmodule // tb
